// ===== rstc_pkg.sv
// Purpose: Shared constants for the reset controller and its register file
// Assumes: One system clock, 8-bit registers, 32-bit classic Wishbone data path
// Notes: Word index times four gives the byte address on the bus
package rstc_pkg;

  // Register file geometry
  localparam int RSTC_NREG = 49;
  localparam int RSTC_IW = 6;
  localparam int RSTC_PORT_W = 8;

  // Word indices of registers the controller itself looks at
  localparam int RSTC_IX_PSW = 0;
  localparam int RSTC_IX_PLATCH = 1;
  localparam int RSTC_IX_PDIR = 2;
  localparam int RSTC_IX_PCC = 5;
  localparam int RSTC_IX_T16 = 10;
  localparam int RSTC_IX_T8 = 20;
  localparam int RSTC_IX_ADM = 30;
  localparam int RSTC_IX_WATCHDOG_MODE_REG = 26;
  localparam int RSTC_IX_WATCHDOG_ENABLE_REG = 27;
  localparam int RSTC_IX_UCTL = 39;
  localparam int RSTC_IX_MASK0 = 43;
  localparam int RSTC_IX_LVCTL = 47;
  localparam int RSTC_IX_LVLVL = 48;
  localparam int RSTC_IX_CAUSE = 50;
  localparam int RSTC_IX_STAT = 51;

  // Values loaded when the stabilisation wait ends, by word index
  localparam logic [7:0] RSTC_INIT [RSTC_NREG] = '{
    8'h02, 8'h00, 8'hff, 8'h00, 8'h00, 8'h02, 8'h02, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h67, 8'h9a, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hff, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'hff, 8'h16,
    8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00,
    8'h00
  };
  // Entries 9, 21, 28 and 29 have no reset value and are never loaded
  localparam logic [RSTC_NREG-1:0] RSTC_DEFINED = 49'h1_ffff_cfdf_fdff;
  // Low-voltage control and level entries survive a low-voltage-only reset
  localparam logic [RSTC_NREG-1:0] RSTC_LVMASK = 49'h1_8000_0000_0000;

  // Cause flag positions
  localparam int RSTC_LVI_BIT = 0;
  localparam int RSTC_WDT_BIT = 4;

  // Reset vector table
  localparam logic [15:0] RSTC_VEC_LO = 16'h0000;
  localparam logic [15:0] RSTC_VEC_HI = 16'h0001;

  // Stabilisation wait after the last request drops
  localparam int RSTC_CLK_NS = 4;
  localparam int RSTC_STAB_NS = 400;
  localparam int RSTC_STAB_CYC = (RSTC_STAB_NS + RSTC_CLK_NS - 1) / RSTC_CLK_NS;

  // Default position of the reset indicator in the port
  localparam int RSTC_IND_BIT = 0;

  // Sequencer states, Gray coded along hold, wait, fetch, load
  typedef enum logic [2:0] {
    RSTC_IDLE = 3'b000,
    RSTC_HOLD = 3'b001,
    RSTC_STAB = 3'b011,
    RSTC_FLO = 3'b010,
    RSTC_FHI = 3'b110,
    RSTC_LOAD = 3'b111
  } rstc_state_e;

endpackage

// ===== rstc_regfile.sv
// Purpose: Peripheral register images with per-entry reset values
// Assumes: One writer; init and write never needed in the same cycle
// Notes: Entries without a defined reset value keep their contents
`timescale 1ns/10ps
module rstc_regfile import rstc_pkg::*; #(
  parameter int N = RSTC_NREG
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic init_i,
  input wire logic keep_lv_i,
  input wire logic wr_i,
  input wire logic [RSTC_IW-1:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  output logic [N*8-1:0] q_o
);

  logic [7:0] mem [N];

  // One byte register per entry; init has priority over a software write
  for (genvar i = 0; i < N; i++) begin : g_ent
    always_ff @(posedge clk_i) begin
      if ((rst_i || init_i) && RSTC_DEFINED[i] && !(keep_lv_i && RSTC_LVMASK[i])) begin
        mem[i] <= RSTC_INIT[i];
      end else if (wr_i && wr_idx_i == RSTC_IW'(i)) begin
        mem[i] <= wr_data_i;
      end
    end
    assign q_o[i*8 +: 8] = mem[i];
  end

endmodule

// ===== rstc_top.sv
// Purpose: Merge reset sources, sequence the internal reset, keep the cause
// Assumes: Requests and vector data are synchronous to clk_i
// Notes: Vector bytes return one cycle after vec_rd_o; bus is classic Wishbone
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
module rstc_top import rstc_pkg::*; #(
  parameter int STAB_CYC = RSTC_STAB_CYC,
  parameter int IND_BIT = RSTC_IND_BIT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_req_i,
  input wire logic wdt_req_i,
  input wire logic poc_req_i,
  input wire logic lvi_req_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic sys_rst_o,
  output logic wdt_rst_o,
  output logic vec_rd_o,
  output logic [15:0] vec_addr_o,
  input wire logic [7:0] vec_data_i,
  output logic [15:0] pc_o,
  output logic pc_load_o,
  output logic pc_valid_o,
  output logic [RSTC_PORT_W-1:0] port_out_o,
  output logic [RSTC_PORT_W-1:0] port_oe_o,
  output logic [RSTC_NREG*8-1:0] regs_o
);

  localparam logic [RSTC_PORT_W-1:0] IND_MASK = RSTC_PORT_W'(1) << IND_BIT;

  rstc_state_e state;
  rstc_state_e next_state;
  logic [15:0] stab_cnt;
  logic [7:0] cause;
  logic [7:0] cause_set;
  logic [7:0] vec_lo;
  logic keep_lv;
  logic any_req;
  logic hard_clr;
  logic other_req;
  logic init_go;
  logic next_busy;
  logic bus_take;
  logic [RSTC_IW-1:0] idx;
  logic reg_wr;
  logic rd_cause;
  logic [7:0] rd_val;

  // True for word indices backed by the register file
  function automatic logic reg_hit(input logic [RSTC_IW-1:0] ix);
    reg_hit = int'(ix) < RSTC_NREG;
  endfunction

  // Byte of the register image at a word index
  function automatic logic [7:0] reg_at(input logic [RSTC_NREG*8-1:0] q, input int ix);
    reg_at = q[ix*8 +: 8];
  endfunction

  // Request merging; every source starts the same sequence
  assign any_req = pin_req_i | wdt_req_i | poc_req_i | lvi_req_i;
  assign hard_clr = pin_req_i | poc_req_i;
  assign other_req = pin_req_i | poc_req_i | wdt_req_i;
  assign cause_set = (8'(wdt_req_i) << RSTC_WDT_BIT) | (8'(lvi_req_i) << RSTC_LVI_BIT);

  // Sequencer next state; a fresh request restarts from hold in any state
  always_comb begin
    next_state = state;
    if (any_req) begin
      next_state = RSTC_HOLD;
    end else begin
      case (state)
        RSTC_IDLE: next_state = RSTC_IDLE;
        RSTC_HOLD: next_state = RSTC_STAB;
        RSTC_STAB: begin
          if (stab_cnt == 16'(STAB_CYC - 1)) begin
            next_state = RSTC_FLO;
          end
        end
        RSTC_FLO: next_state = RSTC_FHI;
        RSTC_FHI: next_state = RSTC_LOAD;
        RSTC_LOAD: next_state = RSTC_IDLE;
        default: next_state = RSTC_HOLD;
      endcase
    end
  end

  assign next_busy = next_state != RSTC_IDLE;
  // Register images reload only as the wait ends, so hardware holds until then
  assign init_go = (state == RSTC_STAB) && (next_state == RSTC_FLO);

  // State register; controller reset behaves like power-on clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RSTC_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Stabilisation counter runs only while waiting
  always_ff @(posedge clk_i) begin
    if (rst_i || state != RSTC_STAB) begin
      stab_cnt <= 16'h0000;
    end else begin
      stab_cnt <= stab_cnt + 16'h0001;
    end
  end

  // Internal reset to CPU and peripherals, watchdog included
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_rst_o <= 1'b1;
      wdt_rst_o <= 1'b1;
    end else begin
      sys_rst_o <= next_busy;
      wdt_rst_o <= next_busy;
    end
  end

  // Pins float while in reset, except the indicator which drives low
  always_ff @(posedge clk_i) begin
    if (rst_i || next_busy) begin
      port_out_o <= '0;
      port_oe_o <= IND_MASK;
    end else begin
      port_out_o <= reg_at(regs_o, RSTC_IX_PLATCH);
      port_oe_o <= ~reg_at(regs_o, RSTC_IX_PDIR);
    end
  end

  // Vector fetch; only the two vector bytes are read, data memory is left alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_rd_o <= 1'b0;
      vec_addr_o <= RSTC_VEC_LO;
    end else begin
      vec_rd_o <= (next_state == RSTC_FLO) || (next_state == RSTC_FHI);
      vec_addr_o <= (next_state == RSTC_FHI) ? RSTC_VEC_HI : RSTC_VEC_LO;
    end
  end

  // Low vector byte arrives in the high-fetch cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_lo <= 8'h00;
    end else if (state == RSTC_FHI) begin
      vec_lo <= vec_data_i;
    end
  end

  // Program counter is unknown until the vector is loaded at release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= 16'h0000;
      pc_load_o <= 1'b0;
      pc_valid_o <= 1'b0;
    end else begin
      pc_load_o <= (state == RSTC_LOAD) && !any_req;
      if (state == RSTC_LOAD && !any_req) begin
        pc_o <= {vec_data_i, vec_lo};
        pc_valid_o <= 1'b1;
      end else if (next_busy) begin
        pc_valid_o <= 1'b0;
      end
    end
  end

  // Low-voltage retention: true only if no other source joined this episode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keep_lv <= 1'b0;
    end else if (state == RSTC_IDLE && any_req) begin
      keep_lv <= lvi_req_i && !other_req;
    end else if (other_req) begin
      keep_lv <= 1'b0;
    end
  end

  // Cause flags; a set in the same cycle as a read clear wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause <= 8'h00;
    end else if (hard_clr || rd_cause) begin
      cause <= cause_set;
    end else begin
      cause <= cause | cause_set;
    end
  end

  // Register images loaded from their reset values at the end of the wait
  rstc_regfile #(
    .N(RSTC_NREG)
  ) u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .init_i(init_go),
    .keep_lv_i(keep_lv),
    .wr_i(reg_wr),
    .wr_idx_i(idx),
    .wr_data_i(wb_dat_i[7:0]),
    .q_o(regs_o)
  );

  // Wishbone decode; one wait state, then ack for exactly one cycle
  assign bus_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = wb_adr_i[7:2];
  // CPU is frozen during reset, so writes then are acknowledged but dropped
  assign reg_wr = bus_take && wb_we_i && wb_sel_i[0] && reg_hit(idx) && !sys_rst_o;
  // Any read clears, whatever lanes; software is expected to read the full byte
  assign rd_cause = bus_take && !wb_we_i && idx == RSTC_IW'(RSTC_IX_CAUSE);

  // Read mux; unmapped words read zero
  always_comb begin
    rd_val = 8'h00;
    if (reg_hit(idx)) begin
      rd_val = reg_at(regs_o, int'(idx));
    end else if (idx == RSTC_IW'(RSTC_IX_CAUSE)) begin
      rd_val = cause;
    end else if (idx == RSTC_IW'(RSTC_IX_STAT)) begin
      rd_val = {3'h0, pc_valid_o, keep_lv, state};
    end
  end

  // Acknowledge and read data registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_take;
      if (bus_take && !wb_we_i) begin
        wb_dat_o <= {24'h00_0000, rd_val};
      end
    end
  end

  // Checks on the release sequence and the cause flags

  AST_PORT_SAFE:
  assert property (@(posedge clk_i) disable iff (rst_i)
    sys_rst_o |-> (port_oe_o == IND_MASK) && (port_out_o == '0))
    else $error("pins not safe during reset");

  AST_WDT_INIT:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(sys_rst_o) |-> (reg_at(regs_o, RSTC_IX_WATCHDOG_MODE_REG) == 8'h67)
      && (reg_at(regs_o, RSTC_IX_WATCHDOG_ENABLE_REG) == 8'h9a))
    else $error("watchdog registers wrong after reset");

  AST_PC_VECTOR:
  assert property (@(posedge clk_i) disable iff (rst_i)
    pc_load_o |-> (pc_o == {$past(vec_data_i, 1), $past(vec_data_i, 2)})
      && $past(vec_addr_o, 2) == RSTC_VEC_HI && $fell(sys_rst_o))
    else $error("program counter not loaded from vector");

  AST_PSW_INIT:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(sys_rst_o) |-> reg_at(regs_o, RSTC_IX_PSW) == 8'h02)
    else $error("status word wrong after reset");

  AST_PC_HIDDEN:
  assert property (@(posedge clk_i) disable iff (rst_i)
    sys_rst_o |-> !pc_valid_o ##0 (pc_load_o == $fell(sys_rst_o)))
    else $error("program counter valid during reset");

  AST_PORT_INIT:
  assert property (@(posedge clk_i) disable iff (rst_i)
    init_go |=> (reg_at(regs_o, RSTC_IX_PLATCH) == 8'h00)
      && (reg_at(regs_o, RSTC_IX_PDIR) == 8'hff) ##3 (port_oe_o == 8'h00))
    else $error("port registers wrong after reset");

  AST_CLK_INIT:
  assert property (@(posedge clk_i) disable iff (rst_i)
    init_go |=> reg_at(regs_o, RSTC_IX_PCC) == 8'h02)
    else $error("clock control wrong after reset");

  AST_T16_INIT:
  assert property (@(posedge clk_i) disable iff (rst_i)
    init_go |=> (reg_at(regs_o, RSTC_IX_T16) == 8'h00)
      && (reg_at(regs_o, RSTC_IX_T16 + 1) == 8'h00))
    else $error("sixteen-bit timer not cleared");

  AST_T8_INIT:
  assert property (@(posedge clk_i) disable iff (rst_i)
    init_go |=> reg_at(regs_o, RSTC_IX_T8) == 8'h00)
    else $error("eight-bit timer not cleared");

  AST_ADC_INIT:
  assert property (@(posedge clk_i) disable iff (rst_i)
    init_go |=> reg_at(regs_o, RSTC_IX_ADM) == 8'h00)
    else $error("converter mode not cleared");

  AST_UART_INIT:
  assert property (@(posedge clk_i) disable iff (rst_i)
    init_go |=> reg_at(regs_o, RSTC_IX_UCTL) == 8'h16)
    else $error("serial control wrong after reset");

  AST_MASK_INIT:
  assert property (@(posedge clk_i) disable iff (rst_i)
    init_go |=> reg_at(regs_o, RSTC_IX_MASK0) == 8'hff)
    else $error("interrupt mask wrong after reset");

  AST_LV_CLEAR:
  assert property (@(posedge clk_i) disable iff (rst_i)
    init_go && !keep_lv |=> (reg_at(regs_o, RSTC_IX_LVCTL) == 8'h00)
      && (reg_at(regs_o, RSTC_IX_LVLVL) == 8'h00))
    else $error("low-voltage registers not cleared");

  AST_LV_KEEP:
  assert property (@(posedge clk_i) disable iff (rst_i)
    init_go && keep_lv |=> reg_at(regs_o, RSTC_IX_LVCTL)
      == $past(reg_at(regs_o, RSTC_IX_LVCTL)))
    else $error("low-voltage control lost on low-voltage reset");

  AST_CAUSE_RDCLR:
  assert property (@(posedge clk_i) disable iff (rst_i)
    rd_cause && !any_req |=> cause == 8'h00 ##1 wb_dat_o[7:0] == $past(cause, 2))
    else $error("cause register not cleared by read");

  AST_CAUSE_HARD:
  assert property (@(posedge clk_i) disable iff (rst_i)
    hard_clr && !wdt_req_i && !lvi_req_i |=> cause == 8'h00)
    else $error("cause register not cleared by pin or power-on reset");

  AST_WDT_FLAG:
  assert property (@(posedge clk_i) disable iff (rst_i)
    wdt_req_i |=> cause[RSTC_WDT_BIT])
    else $error("watchdog flag not set");

  AST_WDT_HELD:
  assert property (@(posedge clk_i) disable iff (rst_i)
    lvi_req_i && !other_req && !rd_cause |=> cause[RSTC_LVI_BIT]
      && cause[RSTC_WDT_BIT] == $past(cause[RSTC_WDT_BIT]))
    else $error("low-voltage reset disturbed watchdog flag");

  AST_ONE_RESET:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(any_req) |=> sys_rst_o [*3])
    else $error("internal reset not held after request");

endmodule

// ===== rstc_vec_model.sv
// Purpose: Reset vector memory answering the sequencer's fetch strobes
// Assumes: A byte is due the cycle after the strobe, as the sequencer expects
// Notes: Outside a fetch the bus toggles so a stale byte is never mistaken for data
`timescale 1ns/10ps
module rstc_vec_model import rstc_pkg::*; #(
  parameter logic [7:0] LO = 8'h5a,
  parameter logic [7:0] HI = 8'h3c
) (
  input wire logic clk_i,
  input wire logic vec_rd_i,
  input wire logic [15:0] vec_addr_i,
  output logic [7:0] vec_data_o
);
  logic [7:0] d = 8'h00;

  // One-cycle read latency; unknown addresses and idle cycles give junk
  always_ff @(posedge clk_i) begin
    if (vec_rd_i && vec_addr_i == RSTC_VEC_LO) begin
      d <= LO;
    end else if (vec_rd_i && vec_addr_i == RSTC_VEC_HI) begin
      d <= HI;
    end else begin
      d <= ~d;
    end
  end
  assign vec_data_o = d;
endmodule

// ===== test_reset_controller_cause_flags.sv
// Purpose: Self-checking bench for the reset sequencer and its cause register
// Assumes: Short stabilisation wait; vector model supplies a known start address
// Notes: Bus answers are taken at the rising edge; other outputs at the falling edge
`timescale 1ns/10ps
module test_reset_controller_cause_flags;
  import rstc_pkg::*;
  localparam int SC = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin = 1'b0, wdt = 1'b0, power_on_clear = 1'b0, lowvolt_detector = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, srst, wrst, vrd, pcld, pcv;
  logic [15:0] vadr, pc;
  logic [7:0] vdat, pout, poe;
  logic [RSTC_NREG*8-1:0] regs;
  int fails = 0;
  int n_tests = 0;

  // 250 MHz system clock
  always #2 clk_i = ~clk_i;

  rstc_top #(.STAB_CYC(SC), .IND_BIT(0)) rstc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .pin_req_i(pin), .wdt_req_i(wdt), .poc_req_i(power_on_clear),
    .lvi_req_i(lowvolt_detector), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sys_rst_o(srst),
    .wdt_rst_o(wrst), .vec_rd_o(vrd), .vec_addr_o(vadr), .vec_data_i(vdat), .pc_o(pc),
    .pc_load_o(pcld), .pc_valid_o(pcv), .port_out_o(pout), .port_oe_o(poe), .regs_o(regs)
  );

  rstc_vec_model #(.LO(8'h5a), .HI(8'h3c)) rstc_vec_model_inst (
    .clk_i(clk_i), .vec_rd_i(vrd), .vec_addr_i(vadr), .vec_data_o(vdat)
  );

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One classic cycle: hold everything until ack is sampled high, release at that edge
  task automatic bus(input logic w, input int idx, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= 8'(idx * 4);
    sel <= 4'hf;
    wdat <= {24'h0, d};
    // Values read here are those before this edge's updates, as a master samples them
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input int idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input int idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk8(q[7:0], exp);
    chk8(q[31:24] | q[23:16] | q[15:8], 8'h00);
  endtask

  // Wait for the program counter load that ends the episode, then check it
  task automatic wait_done;
    int n;
    n = 0;
    while (pcld !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    // A sequence that never ends must not pass on a stale program counter
    if (pcld !== 1'b1) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    end
    chk16(pc, 16'h3c5a);
    chk8({7'h0, srst}, 8'h00);
    @(negedge clk_i);
    chk8({7'h0, pcv}, 8'h01);
  endtask

  // Raise one request for one cycle; k: 0 pin, 1 watchdog, 2 power-on, 3 low-voltage
  task automatic req(input int k);
    @(posedge clk_i);
    {pin, wdt, power_on_clear, lowvolt_detector} <= 4'b1000 >> k;
    @(posedge clk_i);
    {pin, wdt, power_on_clear, lowvolt_detector} <= 4'b0000;
    @(negedge clk_i);
    chk8({7'h0, srst}, 8'h01);
    chk8(poe, 8'h01);
    chk8(pout, 8'h00);
    chk8({7'h0, pcv}, 8'h00);
    if (k == 1) begin
      chk8({7'h0, wrst}, 8'h01);
    end
    wait_done();
  endtask

  task automatic test_defaults;
    logic [7:0] ix [10] = '{0, 1, 2, 5, 26, 27, 34, 39, 43, 47};
    logic [7:0] ex [10] = '{8'h02, 8'h00, 8'hff, 8'h02, 8'h67, 8'h9a, 8'h01, 8'h16, 8'hff, 8'h00};
    wait_done();
    chk8(poe, 8'h00);
    for (int i = 0; i < 10; i++) begin
      rd_chk(ix[i], ex[i]);
    end
    rd_chk(50, 8'h00);
    rd_chk(38, 8'hff);
    rd_chk(51, 8'h10);
    wr(49, 8'h77);
    rd_chk(49, 8'h00);
    // Out of reset the pins follow latch and direction
    wr(1, 8'ha5);
    wr(2, 8'h0f);
    @(negedge clk_i);
    chk8(pout, 8'ha5);
    chk8(poe, 8'hf0);
    $display("test_defaults done");
  endtask

  // Low-voltage reset keeps its own settings; other state holds until the wait ends
  task automatic test_lv_keep;
    wr(47, 8'h82);
    wr(48, 8'h05);
    wr(1, 8'h55);
    @(posedge clk_i);
    lowvolt_detector <= 1'b1;
    @(posedge clk_i);
    lowvolt_detector <= 1'b0;
    @(negedge clk_i);
    chk8(regs[15:8], 8'h55);
    chk8(poe, 8'h01);
    // A write while the core is held must be dropped
    wr(47, 8'h00);
    wait_done();
    chk8(regs[15:8], 8'h00);
    rd_chk(47, 8'h82);
    rd_chk(48, 8'h05);
    rd_chk(51, 8'h18);
    $display("test_lv_keep done");
  endtask

  // Watchdog flag joins the held low-voltage flag; a read clears both
  task automatic test_wdt_hold;
    wr(26, 8'h11);
    wr(10, 8'h33);
    wr(20, 8'h44);
    wr(30, 8'h66);
    req(1);
    rd_chk(50, 8'h11);
    rd_chk(50, 8'h00);
    rd_chk(26, 8'h67);
    rd_chk(47, 8'h00);
    rd_chk(10, 8'h00);
    rd_chk(20, 8'h00);
    rd_chk(30, 8'h00);
    req(3);
    req(1);
    rd_chk(50, 8'h11);
    $display("test_wdt_hold done");
  endtask

  // Pin and power-on resets wipe earlier cause flags
  task automatic test_pin_poc;
    req(3);
    req(0);
    rd_chk(50, 8'h00);
    req(1);
    req(2);
    rd_chk(50, 8'h00);
    req(3);
    rd_chk(50, 8'h01);
    $display("test_pin_poc done");
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    chk8(poe, 8'h01);
    @(posedge clk_i);
    rst_i <= 1'b0;
    test_defaults();
    test_lv_keep();
    test_wdt_hold();
    test_pin_poc();
    wrap_up();
  end

  // Watchdog well beyond the expected run time of a few hundred cycles
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule
